// ===== hdl/cpu_alu_pkg.sv
package cpu_alu_pkg;

	// ==========================================================
	// Operation codes written into the command register
	localparam logic [3:0] OP_NOP    = 4'h0;
	localparam logic [3:0] OP_SLEEP  = 4'h1;
	localparam logic [3:0] OP_SBC    = 4'h2; // subtract_with_borrow_reg
	localparam logic [3:0] OP_SUB    = 4'h3; // subtract_acc_from_reg
	localparam logic [3:0] OP_SUBI   = 4'h4; // subtract_acc_from_literal
	localparam logic [3:0] OP_SWAP   = 4'h5; // nibble_swap_reg
	localparam logic [3:0] OP_TBL    = 4'h6; // table_lookup_jump
	localparam logic [3:0] OP_XOR    = 4'h7; // xor_acc_with_reg
	localparam logic [3:0] OP_XORI   = 4'h8; // xor_literal_into_acc
	localparam logic [3:0] OP_PAGE   = 4'h9; // page_select_buffer load
	localparam logic [3:0] OP_WAKE   = 4'hA;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_CMD    = 8'h00;
	localparam logic [7:0] OFS_ACC    = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_RESULT = 8'h0C;
	localparam logic [7:0] OFS_PC     = 8'h10;
	localparam logic [7:0] OFS_PAGE   = 8'h14;
	localparam logic [7:0] OFS_WDT    = 8'h18;

	// ==========================================================
	// Command register fields
	localparam int CMD_OP_LSB   = 0;
	localparam int CMD_DEST_BIT = 4;
	localparam int CMD_VAL_LSB  = 8;
	localparam int CMD_PAGE_LSB = 16;

	// Status and result register fields
	localparam int ST_C     = 0;
	localparam int ST_DC    = 1;
	localparam int ST_Z     = 2;
	localparam int ST_PD    = 3;
	localparam int ST_TO    = 4;
	localparam int ST_SLEEP = 5;
	localparam int RES_WB   = 8;

	// ==========================================================
	// Reset values and sizes
	localparam logic [7:0]  ACC_RST   = 8'h00;
	localparam logic [11:0] PC_RST    = 12'h000;
	localparam logic [1:0]  PAGE_RST  = 2'h0;
	localparam logic        TO_RST    = 1'b1;
	localparam logic        PD_RST    = 1'b1;
	localparam logic [2:0]  HSIZE_WORD = 3'h2;
	localparam int          PRESCALE_W = 8;
	localparam int          WDT_W      = 8;

	typedef enum logic {RUN, HALTED} run_state_type;

endpackage

// ===== hdl/alu_core.sv
`timescale 1ns/1ps
`default_nettype none
module alu_core
	import cpu_alu_pkg::*;
(
	input  wire logic [3:0] op_i,      // Operation code
	input  wire logic [7:0] acc_i,     // Accumulator value
	input  wire logic [7:0] operand_i, // Register value or literal
	input  wire logic       carry_i,   // Current carry flag
	input  wire logic [7:0] pc_lo_i,   // Program counter low byte
	output logic      [7:0] result_o,  // Eight-bit result
	output logic            carry_o,   // Carry out, high when no borrow
	output logic            digit_o,   // Carry out of bit 3
	output logic            zero_o,    // Result is zero
	output logic            upd_cdc_o, // Operation affects carry and digit carry
	output logic            upd_z_o    // Operation affects zero flag
);
	// ==========================================================
	// Operand selection
	// Subtraction reuses the adder: x plus inverted accumulator plus carry in
	wire is_sbc   = (op_i == OP_SBC);
	wire is_sub   = (op_i == OP_SUB) | (op_i == OP_SUBI);
	wire is_tbl   = (op_i == OP_TBL);
	wire is_xor   = (op_i == OP_XOR) | (op_i == OP_XORI);
	wire is_swap  = (op_i == OP_SWAP);
	wire [7:0] x  = is_tbl ? pc_lo_i : operand_i;
	wire [7:0] y  = (is_sbc | is_sub) ? ~acc_i : acc_i;
	wire       ci = is_sbc ? carry_i : is_sub;

	// ==========================================================
	// Adder and nibble adder
	wire [8:0] sum9 = {1'b0, x} + {1'b0, y} + {8'h00, ci};
	wire [4:0] nib5 = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};

	// ==========================================================
	// Result and flag selection
	assign result_o  = is_xor ? (acc_i ^ operand_i) :
	                   is_swap ? {operand_i[3:0], operand_i[7:4]} : sum9[7:0];
	assign carry_o   = sum9[8];
	assign digit_o   = nib5[4];
	assign zero_o    = (result_o == 8'h00);
	assign upd_cdc_o = is_sbc | is_sub | is_tbl;
	assign upd_z_o   = is_sbc | is_sub | is_tbl | is_xor;
endmodule
`default_nettype wire

// ===== hdl/cpu_alu_sleep_table_ops.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_alu_sleep_table_ops
	import cpu_alu_pkg::*;
#(
	parameter int PRESCALE_WIDTH = cpu_alu_pkg::PRESCALE_W, // Watchdog prescaler width
	parameter int WDT_WIDTH      = cpu_alu_pkg::WDT_W       // Watchdog counter width
)(
	input  wire logic        clk_i,       // 200 MHz core clock
	input  wire logic        reset_i,     // Asynchronous reset, active high
	input  wire logic        clk_en_i,    // Freezes all state while low
	input  wire logic        hsel_i,      // AHB slave select
	input  wire logic [31:0] haddr_i,     // AHB address
	input  wire logic [1:0]  htrans_i,    // AHB transfer type
	input  wire logic        hwrite_i,    // AHB write
	input  wire logic [2:0]  hsize_i,     // AHB size
	input  wire logic [31:0] hwdata_i,    // AHB write data
	input  wire logic        hready_i,    // AHB bus ready
	output logic      [31:0] hrdata_o,    // AHB read data
	output logic             hreadyout_o, // AHB slave ready
	output logic             hresp_o,     // AHB response, always OKAY
	output logic             sleep_o,     // Processor halted in sleep
	output logic [7:0]       acc_o        // Working accumulator
);
	import cpu_alu_pkg::*;

	// ==========================================================
	// State
	run_state_type              state_ff;
	logic [7:0]                 acc_ff;
	logic [7:0]                 result_ff;
	logic                       wb_ff;
	logic                       c_ff;
	logic                       dc_ff;
	logic                       z_ff;
	logic                       to_ff;
	logic                       pd_ff;
	logic [11:0]                pc_ff;
	logic [1:0]                 page_ff;
	logic [PRESCALE_WIDTH-1:0]  pres_ff;
	logic [WDT_WIDTH-1:0]       wdt_ff;
	logic                       wr_pend_ff;
	logic [7:0]                 wr_addr_ff;
	logic [31:0]                hrdata_ff;

	// ==========================================================
	// Bus address phase decode
	// Only whole-word writes are acted upon; other writes complete with no effect, reads of any size return data
	wire        access_go = hsel_i & hready_i & htrans_i[1];
	wire        word_acc  = (hsize_i == HSIZE_WORD);
	wire        rd_go     = access_go & ~hwrite_i;
	wire        wr_go     = access_go & hwrite_i & word_acc;
	wire [7:0]  rd_addr   = haddr_i[7:0];
	wire        hi_zero   = (haddr_i[31:8] == 24'h000000);

	// ==========================================================
	// Read data selection, unmapped offsets read as zero
	wire [31:0] status_w = {26'h0, (state_ff == HALTED), to_ff, pd_ff, z_ff, dc_ff, c_ff};
	wire [31:0] rd_mux =
		~hi_zero              ? 32'h00000000 :
		(rd_addr == OFS_ACC)    ? {24'h0, acc_ff} :
		(rd_addr == OFS_STATUS) ? status_w :
		(rd_addr == OFS_RESULT) ? {23'h0, wb_ff, result_ff} :
		(rd_addr == OFS_PC)     ? {20'h0, pc_ff} :
		(rd_addr == OFS_PAGE)   ? {30'h0, page_ff} :
		(rd_addr == OFS_WDT)    ? {{(32-WDT_WIDTH){1'b0}}, wdt_ff} :
		32'h00000000;

	// ==========================================================
	// Data phase write decode
	wire sw_cmd    = wr_pend_ff & (wr_addr_ff == OFS_CMD);
	wire sw_acc    = wr_pend_ff & (wr_addr_ff == OFS_ACC);
	wire sw_status = wr_pend_ff & (wr_addr_ff == OFS_STATUS);
	wire sw_pc     = wr_pend_ff & (wr_addr_ff == OFS_PC);

	// ==========================================================
	// Command fields
	wire [3:0] op_w      = hwdata_i[CMD_OP_LSB +: 4];
	wire       dest_w    = hwdata_i[CMD_DEST_BIT];
	wire [7:0] operand_w = hwdata_i[CMD_VAL_LSB +: 8];
	wire [1:0] page_lit  = hwdata_i[CMD_PAGE_LSB +: 2];

	// While halted only the wake command is obeyed
	wire running   = (state_ff == RUN);
	wire exec_ok   = sw_cmd & (running | (op_w == OP_WAKE));
	wire ex_sleep  = exec_ok & (op_w == OP_SLEEP);
	wire ex_tbl    = exec_ok & (op_w == OP_TBL);
	wire ex_page   = exec_ok & (op_w == OP_PAGE);
	wire ex_wake   = exec_ok & (op_w == OP_WAKE);
	wire imm_op    = (op_w == OP_SUBI) | (op_w == OP_XORI);
	wire reg_op    = (op_w == OP_SBC) | (op_w == OP_SUB) |
	                 (op_w == OP_SWAP) | (op_w == OP_XOR);
	wire ex_result = exec_ok & (imm_op | reg_op);
	wire to_acc    = imm_op | (reg_op & ~dest_w);

	// ==========================================================
	// Arithmetic unit
	logic [7:0] alu_res;
	logic       alu_c;
	logic       alu_dc;
	logic       alu_z;
	logic       alu_upd_cdc;
	logic       alu_upd_z;

	alu_core u_alu (
		.op_i      (op_w),
		.acc_i     (acc_ff),
		.operand_i (operand_w),
		.carry_i   (c_ff),
		.pc_lo_i   (pc_ff[7:0]),
		.result_o  (alu_res),
		.carry_o   (alu_c),
		.digit_o   (alu_dc),
		.zero_o    (alu_z),
		.upd_cdc_o (alu_upd_cdc),
		.upd_z_o   (alu_upd_z)
	);

	// ==========================================================
	// Watchdog: prescaler wraps advance the counter, full wrap is a timeout
	wire pres_full = &pres_ff;
	wire wdt_ovf   = pres_full & (&wdt_ff);
	wire [PRESCALE_WIDTH-1:0] nxt_pres = ex_sleep ? '0 : pres_ff + 1'b1;
	wire [WDT_WIDTH-1:0]      nxt_wdt  = ex_sleep ? '0 :
	                                     pres_full ? wdt_ff + 1'b1 : wdt_ff;

	// ==========================================================
	// Next values of accumulator, result and flags
	wire [7:0] nxt_acc = sw_acc ? hwdata_i[7:0] :
	                     (ex_result & to_acc) ? alu_res : acc_ff;
	wire       upd_cdc = exec_ok & alu_upd_cdc;
	wire       upd_z   = exec_ok & alu_upd_z;
	wire       nxt_c   = upd_cdc ? alu_c : sw_status ? hwdata_i[ST_C] : c_ff;
	wire       nxt_dc  = upd_cdc ? alu_dc : sw_status ? hwdata_i[ST_DC] : dc_ff;
	wire       nxt_z   = upd_z ? alu_z : sw_status ? hwdata_i[ST_Z] : z_ff;
	// Sleep sets timeout; a watchdog expiry clears it, sleep wins if both
	wire       nxt_to  = ex_sleep ? 1'b1 : wdt_ovf ? 1'b0 : to_ff;
	wire       nxt_pd  = ex_sleep ? 1'b0 : pd_ff;

	// ==========================================================
	// Program counter and page bits
	wire [11:0] nxt_pc   = ex_tbl ? {page_ff, pc_ff[9:8], alu_res} :
	                       sw_pc ? hwdata_i[11:0] : pc_ff;
	wire [1:0]  nxt_page = ex_page ? page_lit : page_ff;

	// ==========================================================
	// Run state: sleep halts, wake command or watchdog expiry resumes
	run_state_type nxt_state;
	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			RUN:
			begin
				if (ex_sleep)
					nxt_state = HALTED;
			end
			HALTED:
			begin
				if (ex_wake | wdt_ovf)
					nxt_state = RUN;
			end
		endcase
	end

	// ==========================================================
	// Bus pipeline registers
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
			hrdata_ff  <= 32'h00000000;
		end
		else if (clk_en_i)
		begin
			wr_pend_ff <= wr_go & hi_zero;
			wr_addr_ff <= haddr_i[7:0];
			hrdata_ff  <= rd_go ? rd_mux : 32'h00000000;
		end
	end

	// ==========================================================
	// Datapath registers
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			acc_ff  <= ACC_RST;
			c_ff    <= 1'b0;
			dc_ff   <= 1'b0;
			z_ff    <= 1'b0;
			to_ff   <= TO_RST;
			pd_ff   <= PD_RST;
			pc_ff   <= PC_RST;
			page_ff <= PAGE_RST;
		end
		else if (clk_en_i)
		begin
			acc_ff  <= nxt_acc;
			c_ff    <= nxt_c;
			dc_ff   <= nxt_dc;
			z_ff    <= nxt_z;
			to_ff   <= nxt_to;
			pd_ff   <= nxt_pd;
			pc_ff   <= nxt_pc;
			page_ff <= nxt_page;
		end
	end

	// ==========================================================
	// Register-file write-back value, held until the next register-destination result
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			result_ff <= 8'h00;
			wb_ff     <= 1'b0;
		end
		else if (clk_en_i && ex_result)
		begin
			result_ff <= to_acc ? result_ff : alu_res;
			wb_ff     <= ~to_acc;
		end
	end

	// ==========================================================
	// Watchdog and run state
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			pres_ff  <= '0;
			wdt_ff   <= '0;
			state_ff <= RUN;
		end
		else if (clk_en_i)
		begin
			pres_ff  <= nxt_pres;
			wdt_ff   <= nxt_wdt;
			state_ff <= nxt_state;
		end
	end

	// ==========================================================
	// Outputs: read data, sleep and accumulator from flip-flops, ready and response tied constant
	assign hrdata_o    = hrdata_ff;
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;
	assign sleep_o     = (state_ff == HALTED);
	assign acc_o       = acc_ff;

	// ==========================================================
	// Checks
	// Expected values computed from the operands of the cycle that executes
	wire [7:0] exp_sbc  = operand_w + ~acc_ff + {7'h00, c_ff};
	wire [8:0] exp_sub9 = {1'b0, operand_w} - {1'b0, acc_ff};
	wire [7:0] exp_xor  = operand_w ^ acc_ff;
	wire [7:0] exp_tbl  = pc_ff[7:0] + acc_ff;

	a_sleep_flags: assert property (@(posedge clk_i) disable iff (reset_i)
		(clk_en_i && ex_sleep) |=> (to_ff && !pd_ff))
		else $error("sleep did not set timeout and clear powerdown");

	a_sleep_wdt_clear: assert property (@(posedge clk_i) disable iff (reset_i)
		(clk_en_i && ex_sleep) |=> (wdt_ff == '0) && (pres_ff == '0))
		else $error("sleep did not clear watchdog and prescaler");

	a_sleep_halts: assert property (@(posedge clk_i) disable iff (reset_i)
		(clk_en_i && ex_sleep) |=> sleep_o)
		else $error("sleep did not halt");

	a_dest_register: assert property (@(posedge clk_i) disable iff (reset_i)
		(clk_en_i && exec_ok && reg_op && dest_w) |=> ($stable(acc_ff) && wb_ff))
		else $error("register destination touched the accumulator");

	a_sbc_value: assert property (@(posedge clk_i) disable iff (reset_i)
		(clk_en_i && exec_ok && op_w == OP_SBC && !dest_w) |=> (acc_ff == $past(exp_sbc)))
		else $error("subtract with borrow result wrong");

	a_sub_borrow: assert property (@(posedge clk_i) disable iff (reset_i)
		(clk_en_i && exec_ok && op_w == OP_SUB)
		|=> (c_ff == !$past(exp_sub9[8])) && (z_ff == ($past(exp_sub9[7:0]) == 8'h00)))
		else $error("subtract carry or zero wrong");

	a_subi_to_acc: assert property (@(posedge clk_i) disable iff (reset_i)
		(clk_en_i && exec_ok && op_w == OP_SUBI) |=> (acc_ff == $past(exp_sub9[7:0])))
		else $error("literal subtract did not reach the accumulator");

	a_swap_keeps_flags: assert property (@(posedge clk_i) disable iff (reset_i)
		(clk_en_i && exec_ok && op_w == OP_SWAP && !sw_status)
		|=> $stable(c_ff) && $stable(dc_ff) && $stable(z_ff))
		else $error("nibble swap changed a flag");

	a_table_pc: assert property (@(posedge clk_i) disable iff (reset_i)
		(clk_en_i && ex_tbl)
		|=> (pc_ff[7:0] == $past(exp_tbl)) && (pc_ff[9:8] == $past(pc_ff[9:8]))
		    && (pc_ff[11:10] == $past(page_ff)))
		else $error("table look-up program counter wrong");

	a_xor_reg_dest: assert property (@(posedge clk_i) disable iff (reset_i)
		(clk_en_i && exec_ok && op_w == OP_XOR && dest_w) |=> (result_ff == $past(exp_xor)))
		else $error("register exclusive-OR result wrong");

	a_xori_zero: assert property (@(posedge clk_i) disable iff (reset_i)
		(clk_en_i && exec_ok && op_w == OP_XORI)
		|=> (z_ff == (acc_ff == 8'h00)) && (acc_ff == $past(exp_xor)))
		else $error("literal exclusive-OR result or zero flag wrong");

	a_page_load: assert property (@(posedge clk_i) disable iff (reset_i)
		(clk_en_i && ex_page) |=> (page_ff == $past(page_lit)))
		else $error("page bits not loaded");

	a_halt_ignores: assert property (@(posedge clk_i) disable iff (reset_i)
		(clk_en_i && sleep_o && sw_cmd && op_w != OP_WAKE && !sw_acc) |=> $stable(acc_ff))
		else $error("halted core executed a command");
endmodule
`default_nettype wire

// ===== sim/cpu_alu_sleep_table_ops_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_alu_sleep_table_ops_tb;
	import cpu_alu_pkg::*;

	// ==========================================================
	// Bench signals and reference state
	logic        clk;
	logic        reset;
	logic        clk_en;
	logic        hsel;
	logic        hwrite;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        sleep;
	logic [7:0]  acc_out;
	logic        rd_dp;
	logic [31:0] exp_q[$];
	string       name_q[$];
	int          mismatches;
	int          n_tests;
	logic [31:0] rnd;
	logic [7:0]  m_accum;
	logic [7:0]  m_res;
	logic [11:0] m_pc;
	logic [1:0]  m_page;
	logic        m_c;
	logic        m_half;
	logic        m_z;
	logic        m_tmo;
	logic        m_pdn;
	logic        m_halt;

	// Full-size watchdog: the overflow scenario fits inside the run
	cpu_alu_sleep_table_ops #(.PRESCALE_WIDTH(8), .WDT_WIDTH(8)) DUT (
		.clk_i(clk), .reset_i(reset), .clk_en_i(clk_en), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
		.hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
		.sleep_o(sleep), .acc_o(acc_out));

	// ==========================================================
	// Clock, comparison and closing
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	function automatic logic [31:0] next_rnd(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
	endfunction

	function automatic logic [31:0] st_word();
		return {26'h0, m_halt, m_tmo, m_pdn, m_z, m_half, m_c};
	endfunction

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Monitor: read data is settled by mid data phase, so look at the falling edge
	always @(negedge clk)
	begin
		if (rd_dp === 1'b1 && hreadyout === 1'b1 && exp_q.size() > 0)
			check(name_q.pop_front(), hrdata, exp_q.pop_front());
	end

	// ==========================================================
	// AHB-Lite single word master
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
			input logic [31:0] e, input string nm, input logic [2:0] sz);
		int k;
		@(posedge clk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= wr;
		hsize  <= sz;
		k = 0;
		do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 50);
		htrans <= 2'h0;
		hwdata <= d;
		if (!wr)
		begin
			exp_q.push_back(e);
			name_q.push_back(nm);
			rd_dp <= 1'b1;
		end
		k = 0;
		do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 50);
		rd_dp <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, {24'h0, a}, d, 32'h0, "", HSIZE_WORD);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		bus(1'b0, {24'h0, a}, 32'h0, e, nm, HSIZE_WORD);
	endtask

	task automatic cmd(input logic [3:0] op, input logic d, input logic [7:0] v,
			input logic [1:0] pg);
		wr(OFS_CMD, {14'h0, pg, v, 3'h0, d, op});
	endtask

	// One instruction against the reference; literal ops get a random dest too
	task automatic do_op(input logic [3:0] op, input logic d, input logic [7:0] r);
		logic [7:0] x;
		logic [7:0] y;
		logic       cin;
		logic [8:0] s;
		logic [4:0] h;
		logic [7:0] res;
		logic       regd;
		x    = (op == OP_TBL) ? m_pc[7:0] : r;
		y    = (op == OP_TBL) ? m_accum : ~m_accum;
		cin  = (op == OP_TBL) ? 1'b0 : ((op == OP_SBC) ? m_c : 1'b1);
		s    = {1'b0, x} + {1'b0, y} + {8'h0, cin};
		h    = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
		res  = (op == OP_SWAP) ? {r[3:0], r[7:4]} : ((op == OP_XOR || op == OP_XORI)
			? (m_accum ^ r) : s[7:0]);
		regd = d && (op == OP_SBC || op == OP_SUB || op == OP_SWAP || op == OP_XOR);
		if (op == OP_SBC || op == OP_SUB || op == OP_SUBI || op == OP_TBL)
		begin
			m_c    = s[8];
			m_half = h[4];
			m_z    = (s[7:0] == 8'h00);
		end
		if (op == OP_XOR || op == OP_XORI)
			m_z = (res == 8'h00);
		if (op == OP_TBL)
			m_pc = {m_page, m_pc[9:8], s[7:0]};
		else if (op == OP_PAGE)
			m_page = r[1:0];
		else if (regd)
			m_res = res;
		else
			m_accum = res;
		cmd(op, d, r, r[1:0]);
		rd(OFS_ACC, {24'h0, m_accum}, "accumulator");
		rd(OFS_STATUS, st_word(), "status");
		rd(OFS_PC, {20'h0, m_pc}, "program counter");
		rd(OFS_PAGE, {30'h0, m_page}, "page select");
		if (regd)
			rd(OFS_RESULT, {23'h0, 1'b1, m_res}, "register result");
		check("acc_o", {24'h0, acc_out}, {24'h0, m_accum});
	endtask

	// ==========================================================
	// Hang guard: the whole sequence needs about 70000 cycles
	initial
	begin
		repeat (95000) @(posedge clk);
		mismatches++;
		$display("FAIL run_time expected finished seen hung");
		complete_run();
	end

	// ==========================================================
	// Main sequence
	initial
	begin
		reset = 1'b1; clk_en = 1'b1; hsel = 1'b0; hwrite = 1'b0; haddr = 32'h0;
		hwdata = 32'h0; htrans = 2'h0; hsize = HSIZE_WORD; rd_dp = 1'b0;
		mismatches = 0; n_tests = 0; rnd = 32'hBB4E1ABC;
		m_accum = 8'h00; m_res = 8'h00; m_pc = 12'h000; m_page = 2'h0; m_c = 1'b0;
		m_half = 1'b0; m_z = 1'b0; m_tmo = 1'b1; m_pdn = 1'b1; m_halt = 1'b0;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		rd(OFS_STATUS, st_word(), "reset status");
		rd(OFS_ACC, 32'h0, "reset accumulator");
		rd(OFS_WDT, 32'h0, "reset watchdog");
		$display("test reset done");
		// Random operands and flags, each instruction from OP_SBC to OP_PAGE five times
		for (int i = 0; i < 40; i++)
		begin
			rnd = next_rnd(rnd);
			m_accum = rnd[7:0];
			{m_z, m_half, m_c} = rnd[18:16];
			m_pc = rnd[31:20];
			wr(OFS_ACC, {24'h0, rnd[7:0]});
			wr(OFS_STATUS, {29'h0, rnd[18:16]});
			wr(OFS_PC, {20'h0, rnd[31:20]});
			do_op(4'h2 + 4'(i % 8), rnd[19], rnd[15:8]);
		end
		$display("test instructions done");
		// Refused accesses leave state alone
		rd(OFS_CMD, 32'h0, "command readback");
		rd(8'h1C, 32'h0, "unmapped read");
		wr(OFS_PAGE, 32'h3);
		bus(1'b1, 32'h00000104, 32'h55, 32'h0, "", HSIZE_WORD);
		bus(1'b1, {24'h0, OFS_ACC}, 32'hAA, 32'h0, "", 3'h0);
		rd(OFS_PAGE, {30'h0, m_page}, "page after write");
		rd(OFS_ACC, {24'h0, m_accum}, "accumulator after refused");
		$display("test refused done");
		// Watchdog overflow clears the timeout flag, then sleep sets it again
		repeat (66000) @(posedge clk);
		m_tmo = 1'b0;
		rd(OFS_STATUS, st_word(), "status after overflow");
		cmd(OP_SLEEP, 1'b0, 8'h00, 2'h0);
		m_tmo = 1'b1;
		m_pdn = 1'b0;
		m_halt = 1'b1;
		rd(OFS_STATUS, st_word(), "status after sleep");
		rd(OFS_WDT, 32'h0, "watchdog after sleep");
		#1 check("sleep_o", {31'h0, sleep}, 32'h1);
		// Frozen clock enable: without the freeze the counter would step by now
		@(posedge clk);
		clk_en <= 1'b0;
		repeat (300) @(posedge clk);
		clk_en <= 1'b1;
		rd(OFS_WDT, 32'h0, "watchdog frozen");
		cmd(OP_XORI, 1'b0, 8'hFF, 2'h0);
		rd(OFS_ACC, {24'h0, m_accum}, "accumulator while halted");
		cmd(OP_WAKE, 1'b0, 8'h00, 2'h0);
		#1 check("sleep_o after wake", {31'h0, sleep}, 32'h0);
		$display("test sleep done");
		complete_run();
	end

endmodule
`default_nettype wire
